// ==== hw/nid_map.svh ====
`ifndef NID_MAP_SVH
`define NID_MAP_SVH

`define NID_ADDR_W 8
`define NID_OFS_NODE_ID 8'he8
`define NID_OFS_PHY_ACC 8'hec

`define NID_BIT_VALID 31
`define NID_BIT_ROOT 30
`define NID_BIT_CPS 27
`define NID_BUS_HI 15
`define NID_BUS_LO 6
`define NID_NODE_HI 5
`define NID_NODE_LO 0
`define NID_BUS_RST 10'h3ff
`define NID_NODE_RST 6'h3f

`define NID_BIT_DONE 31
`define NID_RADDR_HI 27
`define NID_RADDR_LO 24
`define NID_RDATA_HI 23
`define NID_RDATA_LO 16
`define NID_BIT_RDREQ 15
`define NID_BIT_WRREQ 14
`define NID_TADDR_HI 11
`define NID_TADDR_LO 8
`define NID_WDATA_HI 7
`define NID_WDATA_LO 0

`endif

// ==== hw/nid_pkg.sv ====
package nid_pkg;

    typedef struct packed {
        logic        write;
        logic [3:0]  addr;
        logic [7:0]  data;
    } nid_phy_req_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [7:0]  data;
    } nid_phy_xfer_t;

    typedef struct packed {
        logic        valid;
        logic        root;
        logic        cable_power_ok;
        logic [5:0]  phy_assigned_node;
    } nid_self_id_t;

    typedef enum logic [2:0] {
        NID_IDLE = 3'h1,
        NID_SEND = 3'h2,
        NID_WAIT = 3'h4
    } nid_req_state_t;

endpackage

// ==== hw/nid_phy_req.sv ====
`include "nid_map.svh"

// Hands one PHY register request to the PHY request channel, then reports it sent
module nid_phy_req (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire nid_pkg::nid_phy_req_t req_i,
    output nid_pkg::nid_phy_req_t req_o,
    output logic req_valid_o,
    input wire logic req_ready_i,
    output logic sent_o
);
    nid_pkg::nid_req_state_t state_q;
    nid_pkg::nid_req_state_t state_d;
    nid_pkg::nid_phy_req_t req_q;
    wire accept = (state_q == nid_pkg::NID_SEND) && req_ready_i;

    always_comb begin
        state_d = state_q;
        case (state_q)
            nid_pkg::NID_IDLE: if (start_i) state_d = nid_pkg::NID_SEND;
            nid_pkg::NID_SEND: if (req_ready_i) state_d = nid_pkg::NID_IDLE;
            default: state_d = nid_pkg::NID_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= nid_pkg::NID_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Request fields frozen at start so software edits cannot tear them
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_q <= '0;
        end else if (start_i && state_q == nid_pkg::NID_IDLE) begin
            req_q <= req_i;
        end
    end

    assign req_o = req_q;
    assign req_valid_o = (state_q == nid_pkg::NID_SEND);
    assign sent_o = accept;
endmodule

// ==== hw/nid_capture.sv ====
`include "nid_map.svh"

// Latches a returned PHY register transfer as one word
module nid_capture (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic xfer_valid_i,
    input wire nid_pkg::nid_phy_xfer_t xfer_i,
    output nid_pkg::nid_phy_xfer_t xfer_o
);
    nid_pkg::nid_phy_xfer_t xfer_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            xfer_q <= '0;
        end else if (xfer_valid_i) begin
            xfer_q <= xfer_i; // [RULE12] [RULE13] [RULE20]
        end
    end

    assign xfer_o = xfer_q;
endmodule

// ==== hw/nid_regs.sv ====
// Overview of operation
// [RULE1] Bus reset clears the node-identity-valid flag.
// [RULE2] Fresh node number from PHY sets the valid flag.
// [RULE3] Root bit set during bus reset when PHY reports root.
// [RULE4] Cable power bit follows PHY cable power report.
// [RULE5] Node-identity reserved bits read zero.
// [RULE6] Bus index is software writable and resets to all ones.
// [RULE7] Node identifier is bus index above node number, 16 bits.
// [RULE8] Node number loaded from PHY after self-id; not writable.
// [RULE9] Software must not run async transmit when node number is 63.
// [RULE10] Setting read or write request clears read-complete flag.
// [RULE11] Returned register transfer sets read-complete flag.
// [RULE12] Returned transfer address captured into bits 27 to 24.
// [RULE13] Returned register contents captured into bits 23 to 16.
// [RULE14] Read request bit set by software, cleared once sent.
// [RULE15] Write request bit set by software, cleared once sent.
// [RULE16] Software never sets both request bits together.
// [RULE17] Bits 11 to 8 hold the target PHY register address.
// [RULE18] Bits 7 to 0 hold write value, unused on reads.
// [RULE19] PHY access reserved bits read zero.
// [RULE20] Returned address, value and flag update in one cycle.
`include "nid_map.svh"

module nid_regs (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [`NID_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Link-side events
    input wire logic bus_reset_i,
    input wire nid_pkg::nid_self_id_t self_id_i,
    input wire logic cable_power_ok_i,
    // PHY request channel
    output nid_pkg::nid_phy_req_t phy_req_o,
    output logic phy_req_valid_o,
    input wire logic phy_req_ready_i,
    // PHY returned register transfer
    input wire logic phy_xfer_valid_i,
    input wire nid_pkg::nid_phy_xfer_t phy_xfer_i,
    // Derived state
    output logic [15:0] node_ident_o,
    output logic node_is_broadcast_o
);
    logic node_id_valid_q;
    logic root_q;
    logic cable_power_ok_q;
    logic [9:0] bus_index_q;
    logic [5:0] phy_assigned_node_q;
    logic phy_read_complete_q;
    logic phy_read_request_q;
    logic phy_write_request_q;
    logic [3:0] phy_target_addr_q;
    logic [7:0] phy_write_value_q;
    logic [31:0] rdata_q;
    nid_pkg::nid_phy_xfer_t returned;
    nid_pkg::nid_phy_req_t req_fields;
    logic req_sent;

    wire sel_node = (reg_addr_i == `NID_OFS_NODE_ID);
    wire sel_phy = (reg_addr_i == `NID_OFS_PHY_ACC);
    wire wr_node = reg_wr_i && sel_node;
    wire wr_phy = reg_wr_i && sel_phy;
    wire set_rd = wr_phy && reg_wdata_i[`NID_BIT_RDREQ];
    wire set_wr = wr_phy && reg_wdata_i[`NID_BIT_WRREQ];
    wire busy = phy_read_request_q || phy_write_request_q;
    // A new request is only launched when none is pending
    wire start = (set_rd || set_wr) && !busy;

    // One driver for the whole struct; both bits set is taken as a read
    assign req_fields = {set_wr && !set_rd, reg_wdata_i[`NID_TADDR_HI:`NID_TADDR_LO],
        reg_wdata_i[`NID_WDATA_HI:`NID_WDATA_LO]};

    nid_phy_req u_req (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .start_i(start),
        .req_i(req_fields),
        .req_o(phy_req_o),
        .req_valid_o(phy_req_valid_o),
        .req_ready_i(phy_req_ready_i),
        .sent_o(req_sent)
    );

    nid_capture u_cap (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .xfer_valid_i(phy_xfer_valid_i),
        .xfer_i(phy_xfer_i),
        .xfer_o(returned)
    );

    // Node identity: valid flag, reset wins only over a stale number
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            node_id_valid_q <= 1'b0;
        end else if (self_id_i.valid) begin
            node_id_valid_q <= 1'b1; // [RULE2]
        end else if (bus_reset_i) begin
            node_id_valid_q <= 1'b0; // [RULE1]
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            root_q <= 1'b0;
            phy_assigned_node_q <= `NID_NODE_RST;
        end else if (self_id_i.valid) begin
            root_q <= self_id_i.root; // [RULE3]
            phy_assigned_node_q <= self_id_i.phy_assigned_node; // [RULE8]
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cable_power_ok_q <= 1'b0;
        end else begin
            cable_power_ok_q <= cable_power_ok_i; // [RULE4]
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_index_q <= `NID_BUS_RST; // [RULE6]
        end else if (wr_node) begin
            bus_index_q <= reg_wdata_i[`NID_BUS_HI:`NID_BUS_LO]; // [RULE6]
        end
    end

    // Request bits: hardware clears once the PHY channel took the request
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phy_read_request_q <= 1'b0;
            phy_write_request_q <= 1'b0;
        end else if (start) begin
            phy_read_request_q <= set_rd; // [RULE14]
            phy_write_request_q <= set_wr && !set_rd; // [RULE15] [RULE16]
        end else if (req_sent) begin
            phy_read_request_q <= 1'b0; // [RULE14]
            phy_write_request_q <= 1'b0; // [RULE15]
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phy_target_addr_q <= '0;
            phy_write_value_q <= '0;
        end else if (wr_phy) begin
            phy_target_addr_q <= reg_wdata_i[`NID_TADDR_HI:`NID_TADDR_LO]; // [RULE17]
            phy_write_value_q <= reg_wdata_i[`NID_WDATA_HI:`NID_WDATA_LO]; // [RULE18]
        end
    end

    // Arrival beats the clear so a fast reply is never lost
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phy_read_complete_q <= 1'b0;
        end else if (phy_xfer_valid_i) begin
            phy_read_complete_q <= 1'b1; // [RULE11] [RULE20]
        end else if (start) begin
            phy_read_complete_q <= 1'b0; // [RULE10]
        end
    end

    logic [31:0] node_word;
    logic [31:0] phy_word;

    always_comb begin
        node_word = '0; // [RULE5]
        node_word[`NID_BIT_VALID] = node_id_valid_q;
        node_word[`NID_BIT_ROOT] = root_q;
        node_word[`NID_BIT_CPS] = cable_power_ok_q;
        node_word[`NID_BUS_HI:`NID_BUS_LO] = bus_index_q;
        node_word[`NID_NODE_HI:`NID_NODE_LO] = phy_assigned_node_q;
    end

    always_comb begin
        phy_word = '0; // [RULE19]
        phy_word[`NID_BIT_DONE] = phy_read_complete_q;
        phy_word[`NID_RADDR_HI:`NID_RADDR_LO] = returned.addr; // [RULE12]
        phy_word[`NID_RDATA_HI:`NID_RDATA_LO] = returned.data; // [RULE13]
        phy_word[`NID_BIT_RDREQ] = phy_read_request_q;
        phy_word[`NID_BIT_WRREQ] = phy_write_request_q;
        phy_word[`NID_TADDR_HI:`NID_TADDR_LO] = phy_target_addr_q;
        phy_word[`NID_WDATA_HI:`NID_WDATA_LO] = phy_write_value_q;
    end

    // Unmapped offsets read as zero
    wire [31:0] rd_mux = sel_node ? node_word : (sel_phy ? phy_word : 32'h0000_0000);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign node_ident_o = {bus_index_q, phy_assigned_node_q}; // [RULE7]
    // Lets the DMA side keep async transmit from running with node 63
    assign node_is_broadcast_o = (phy_assigned_node_q == `NID_NODE_RST); // [RULE9]
endmodule

// ==== sim/nid_regs_asserts.sv ====
module nid_regs_asserts (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic bus_reset_i,
    input wire nid_pkg::nid_self_id_t self_id_i,
    input wire nid_pkg::nid_phy_req_t phy_req_o,
    input wire logic phy_req_valid_o,
    input wire logic phy_req_ready_i,
    input wire logic phy_xfer_valid_i,
    input wire nid_pkg::nid_phy_xfer_t phy_xfer_i,
    input wire logic [15:0] node_ident_o,
    input wire logic node_is_broadcast_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    wire rd_id = reg_rd_i && reg_addr_i == 8'he8;
    wire rd_acc = reg_rd_i && reg_addr_i == 8'hec;
    wire sent = phy_req_valid_o && phy_req_ready_i;
    // A request bit set while one is pending is ignored
    wire start = reg_wr_i && reg_addr_i == 8'hec && reg_wdata_i[15:14] != 2'h0
        && !phy_req_valid_o;
    sequence xfer_then_rd;
        phy_xfer_valid_i ##1 rd_acc;
    endsequence
    sequence start_then_rd;
        start && !phy_xfer_valid_i ##1 rd_acc && !phy_xfer_valid_i;
    endsequence
    sequence reset_then_rd;
        bus_reset_i && !self_id_i.valid ##1 rd_id;
    endsequence
    sequence load_then_rd;
        self_id_i.valid ##1 rd_id;
    endsequence
    // One idle cycle between hand-off and read, with no new request in it
    sequence sent_then_rd;
        sent ##1 !start ##1 rd_acc;
    endsequence
    id_rsvd_a: assert property (
        rd_id |=> reg_rdata_o[29:28] == 2'h0 && reg_rdata_o[26:16] == 11'h0)
        else $error("node identity reserved bits set");
    acc_rsvd_a: assert property (
        rd_acc |=> reg_rdata_o[30:28] == 3'h0 && reg_rdata_o[13:12] == 2'h0)
        else $error("phy access reserved bits set");
    reset_clr_a: assert property (
        reset_then_rd |=> !reg_rdata_o[31])
        else $error("valid flag survived bus reset");
    self_id_a: assert property (
        load_then_rd |=> reg_rdata_o[31]
        && reg_rdata_o[30] == $past(self_id_i.root, 2)
        && reg_rdata_o[5:0] == $past(self_id_i.phy_assigned_node, 2))
        else $error("self id not loaded");
    bcast_flag_a: assert property (
        node_is_broadcast_o == (node_ident_o[5:0] == 6'h3f))
        else $error("broadcast flag wrong");
    req_start_a: assert property (
        start |=> phy_req_valid_o && phy_req_o.addr == $past(reg_wdata_i[11:8])
        && phy_req_o.write == !$past(reg_wdata_i[15])
        && (!phy_req_o.write || phy_req_o.data == $past(reg_wdata_i[7:0])))
        else $error("request not issued as written");
    req_hold_a: assert property (
        phy_req_valid_o && !phy_req_ready_i |=> phy_req_valid_o && $stable(phy_req_o))
        else $error("request dropped before ready");
    req_done_a: assert property (
        sent_then_rd |=> reg_rdata_o[15:14] == 2'h0)
        else $error("request bit not cleared once sent");
    xfer_cap_a: assert property (
        xfer_then_rd |=> reg_rdata_o[31]
        && reg_rdata_o[27:16] == $past({phy_xfer_i.addr, phy_xfer_i.data}, 2))
        else $error("returned transfer not captured");
    done_clr_a: assert property (
        start_then_rd |=> !reg_rdata_o[31])
        else $error("complete flag not cleared by request");
endmodule

bind nid_regs nid_regs_asserts u_chk (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .bus_reset_i(bus_reset_i),
    .self_id_i(self_id_i),
    .phy_req_o(phy_req_o),
    .phy_req_valid_o(phy_req_valid_o),
    .phy_req_ready_i(phy_req_ready_i),
    .phy_xfer_valid_i(phy_xfer_valid_i),
    .phy_xfer_i(phy_xfer_i),
    .node_ident_o(node_ident_o),
    .node_is_broadcast_o(node_is_broadcast_o)
);

// ==== sim/nid_phy_model.sv ====
module nid_phy_model (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic slow_i,
    input wire nid_pkg::nid_phy_req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    output logic xfer_valid_o,
    output nid_pkg::nid_phy_xfer_t xfer_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_q [16];
    logic [1:0] cnt_q;
    // Slow mode holds off ready for three cycles of a standing request
    assign req_ready_o = req_valid_i && (!slow_i || cnt_q == 2'h3);
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 2'h0;
            xfer_valid_o <= 1'b0;
            xfer_o <= '0;
            for (int i = 0; i < 16; i++) mem_q[i] <= {i[3:0], ~i[3:0]};
        end else begin
            cnt_q <= (req_valid_i && !req_ready_o) ? cnt_q + 2'h1 : 2'h0;
            xfer_valid_o <= req_ready_o && !req_i.write;
            // Idle lines toggle so stale data never passes for a transfer
            xfer_o <= (req_ready_o && !req_i.write) ? {req_i.addr, mem_q[req_i.addr]} : ~xfer_o;
            if (req_ready_o && req_i.write) mem_q[req_i.addr] <= req_i.data;
        end
    end
endmodule

// ==== sim/nid_regs_tb.sv ====
module nid_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic wr = 1'b0, rd = 1'b0, bus_reset = 1'b0, cable = 1'b0, slow = 1'b0;
    nid_pkg::nid_self_id_t self_id = '0;
    nid_pkg::nid_phy_req_t req;
    nid_pkg::nid_phy_xfer_t xfer;
    logic req_valid, req_ready, xfer_valid, bcast, w, root = 1'b0, valid = 1'b0, done = 1'b0;
    logic [15:0] ident;
    logic [7:0] shadow [16];
    logic [7:0] d;
    logic [3:0] a;
    logic [11:0] lastx = 12'h0;
    logic [9:0] bus = 10'h3ff;
    logic [5:0] node = 6'h3f;
    int miscompares = 0, n_compared = 0, cyc = 0, k;
    always #25 clk_sys_i = ~clk_sys_i;
    nid_regs dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .bus_reset_i(bus_reset), .self_id_i(self_id), .cable_power_ok_i(cable),
        .phy_req_o(req), .phy_req_valid_o(req_valid), .phy_req_ready_i(req_ready),
        .phy_xfer_valid_i(xfer_valid), .phy_xfer_i(xfer), .node_ident_o(ident),
        .node_is_broadcast_o(bcast));
    nid_phy_model u_phy (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .slow_i(slow),
        .req_i(req), .req_valid_i(req_valid), .req_ready_o(req_ready),
        .xfer_valid_o(xfer_valid), .xfer_o(xfer));
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] v);
        addr <= ad;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        chk(rdata, e);
        @(posedge clk_sys_i);
    endtask
    function automatic logic [31:0] id_word();
        return {valid, root, 2'h0, cable, 11'h0, bus, node};
    endfunction
    function automatic logic [31:0] acc_word(input logic [1:0] rq);
        return {done, 3'h0, lastx, rq, 2'h0, a, d};
    endfunction
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'hcc000cd1));
        for (int i = 0; i < 16; i++) shadow[i] = {i[3:0], ~i[3:0]};
        repeat (8) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_chk(8'he8, id_word());
        rd_chk(8'hec, 32'h0);
        rd_chk(8'h10, 32'h0);
        cable <= 1'b1;
        bus = 10'($urandom);
        wr_reg(8'he8, {16'hffff, bus, 6'h15});
        rd_chk(8'he8, id_word());
        chk({16'h0, ident}, {16'h0, bus, node});
        repeat (3) begin
            node = 6'($urandom);
            root = 1'($urandom);
            self_id <= {1'b1, root, 1'b0, node};
            @(posedge clk_sys_i);
            self_id <= '0;
            valid = 1'b1;
            rd_chk(8'he8, id_word());
            chk({16'h0, ident}, {16'h0, bus, node});
            chk({31'h0, bcast}, {31'h0, node == 6'h3f});
            bus_reset <= 1'b1;
            cable <= 1'($urandom);
            @(posedge clk_sys_i);
            bus_reset <= 1'b0;
            valid = 1'b0;
            rd_chk(8'he8, id_word());
        end
        repeat (12) begin
            a = 4'($urandom);
            d = 8'($urandom);
            w = 1'($urandom);
            slow <= 1'($urandom);
            wr_reg(8'hec, {16'h0, ~w, w, 2'h0, a, d});
            done = 1'b0;
            if (slow) rd_chk(8'hec, acc_word({~w, w}));
            k = 0;
            do begin
                @(negedge clk_sys_i);
                k++;
            end while (req_valid && k < 20);
            if (k == 20) chk(32'h0, 32'h1);
            @(posedge clk_sys_i);
            if (w) shadow[a] = d;
            else begin
                lastx = {a, shadow[a]};
                done = 1'b1;
            end
            rd_chk(8'hec, acc_word(2'h0));
        end
        stop_test();
    end
endmodule
